// File: core/reset_source_pkg.sv
// Purpose: Shared constants, register map and state types of the reset source controller.
// Assumes: 100 MHz clk; AXI4-Lite register access with 32-bit data.
// Notes:   The all-zero state word is the reset state of the controller.
package reset_source_pkg;

  // Least reset low time, in cycles of clk
  localparam int unsigned MIN_LOW_CYCLES = 20;
  localparam int unsigned CNT_W          = 8;

  // Register byte offsets
  localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;

  // Control register fields
  localparam int unsigned CTRL_WDT_EN_BIT     = 0;
  localparam int unsigned CTRL_WDT_MANUAL_BIT = 1;
  localparam int unsigned CTRL_FREQ_LSB       = 8;
  localparam int unsigned FREQ_W              = 8;
  localparam logic [FREQ_W-1:0] FREQ_RESET    = 8'h00;

  // Status register fields
  localparam int unsigned STAT_CAUSE_LSB    = 0;
  localparam int unsigned CAUSE_W           = 4;
  localparam int unsigned CAUSE_PIN_BIT     = 0;
  localparam int unsigned CAUSE_DEBUG_BIT   = 1;
  localparam int unsigned CAUSE_WDT_POR_BIT = 2;
  localparam int unsigned CAUSE_WDT_MAN_BIT = 3;
  localparam int unsigned STAT_POR_BIT      = 8;
  localparam int unsigned STAT_MAN_BIT      = 9;
  localparam int unsigned STAT_DEFER_BIT    = 10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Power-on hold comes first so that an all-zero word is the reset state
  typedef enum logic [2:0] {POR_HOLD_ST, POR_EXC_ST, RUN_ST, MAN_HOLD_ST, MAN_EXC_ST} seq_state_t;
  typedef enum logic [1:0] {SRC_PIN, SRC_DEBUG, SRC_WDT} por_src_t;

  typedef struct packed {
    logic                 pin_meta;
    logic                 pin_sync;
    seq_state_t           state;
    por_src_t             src;
    logic [CNT_W-1:0]     cnt;
    logic                 negate_seen;
    logic                 wdt_en;
    logic                 wdt_manual;
    logic [FREQ_W-1:0]    freq;
    logic [CAUSE_W-1:0]   cause;
    logic                 aw_got;
    logic                 w_got;
    logic [31:0]          awaddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } ctrl_state_t;

endpackage

// File: core/reset_source_control.sv
// Purpose: Sequences power-on and manual reset entry and exit from pin, debug and watchdog sources.
// Assumes: Inputs synchronous to clk except the reset pin, which is synchronised here.
// Notes:   Registers on AXI4-Lite; watchdog and debug port internals live elsewhere.
//
// How it works
// - Pin low holds power-on reset state
// - Exception starts after minimum low, then high
// - Debug assert enters power-on reset state
// - Watchdog power-on reset keeps its settings
// - Watchdog manual mode enters manual reset
// - Manual exception deferred while bus released
// - Manual reset clears processor and bank only
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
module reset_source_control #(
  parameter int unsigned MIN_LOW = reset_source_pkg::MIN_LOW_CYCLES
) (
  input  wire logic                              clk,                      // 100 MHz clock
  input  wire logic                              resetn,                   // Synchronous reset, active low
  input  wire logic                              power_on_reset_n,         // Reset pin, active low
  input  wire logic                              dbg_reset_assert,         // Debug reset assert command pulse
  input  wire logic                              dbg_reset_negate,         // Debug reset negate command pulse
  input  wire logic                              wdt_overflow,             // Watchdog counter overflow pulse
  input  wire logic                              bus_released,             // Processor has released the bus
  input  wire logic                              dma_burst_active,         // DMA burst transfer running
  output logic                                   periph_reset_n,           // Peripheral register reset
  output logic                                   cpu_reset_n,              // Processor reset
  output logic                                   retained_reset_n,         // Reset of watchdog and clock settings
  output logic                                   bank_number_clear,        // Clears the register bank number bit
  output logic                                   por_exception_start,      // Power-on exception start pulse
  output logic                                   manual_exception_start,   // Manual exception start pulse
  output logic                                   watchdog_overflow_out_n,  // Watchdog reset in progress
  output logic [reset_source_pkg::FREQ_W-1:0]    clock_frequency_control,  // Clock frequency setting
  input  wire logic [31:0]                       awaddr,                   // Write address
  input  wire logic                              awvalid,                  // Write address valid
  output logic                                   awready,                  // Write address ready
  input  wire logic [31:0]                       wdata,                    // Write data
  input  wire logic [3:0]                        wstrb,                    // Write byte strobes
  input  wire logic                              wvalid,                   // Write data valid
  output logic                                   wready,                   // Write data ready
  output logic [1:0]                             bresp,                    // Write response
  output logic                                   bvalid,                   // Write response valid
  input  wire logic                              bready,                   // Write response ready
  input  wire logic [31:0]                       araddr,                   // Read address
  input  wire logic                              arvalid,                  // Read address valid
  output logic                                   arready,                  // Read address ready
  output logic [31:0]                            rdata,                    // Read data
  output logic [1:0]                             rresp,                    // Read response
  output logic                                   rvalid,                   // Read data valid
  input  wire logic                              rready                    // Read data ready
);

  localparam logic [reset_source_pkg::CNT_W-1:0] MIN_CNT = reset_source_pkg::CNT_W'(MIN_LOW);

  reset_source_pkg::ctrl_state_t st_ff;
  reset_source_pkg::ctrl_state_t nxt_st;

  logic in_por;
  logic in_man;
  logic bus_busy;
  logic hold_low;

  assign in_por   = (st_ff.state == reset_source_pkg::POR_HOLD_ST);
  assign in_man   = (st_ff.state == reset_source_pkg::MAN_HOLD_ST);
  assign bus_busy = bus_released || dma_burst_active;

  assign awready = !st_ff.aw_got && !st_ff.bvalid;
  assign wready  = !st_ff.w_got && !st_ff.bvalid;
  assign arready = !st_ff.rvalid;
  assign bvalid  = st_ff.bvalid;
  assign bresp   = st_ff.bresp;
  assign rvalid  = st_ff.rvalid;
  assign rdata   = st_ff.rdata;
  assign rresp   = st_ff.rresp;

  assign periph_reset_n          = !in_por;
  assign cpu_reset_n             = !(in_por || in_man);
  assign retained_reset_n        = !(in_por && st_ff.src != reset_source_pkg::SRC_WDT);
  assign bank_number_clear       = in_man;
  assign por_exception_start     = (st_ff.state == reset_source_pkg::POR_EXC_ST);
  assign manual_exception_start  = (st_ff.state == reset_source_pkg::MAN_EXC_ST);
  assign watchdog_overflow_out_n = !((in_por && st_ff.src == reset_source_pkg::SRC_WDT) || in_man);
  assign clock_frequency_control = st_ff.freq;

  always_comb begin
    nxt_st = st_ff;
    hold_low = 1'b0;

    // Two-stage synchroniser on the reset pin
    nxt_st.pin_meta = power_on_reset_n;
    nxt_st.pin_sync = st_ff.pin_meta;

    // Register write, taken once both address and data are held
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (awvalid && awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = wdata;
      nxt_st.wstrb = wstrb;
    end
    if (st_ff.aw_got && st_ff.w_got) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = reset_source_pkg::RESP_OKAY;
      if (st_ff.awaddr == reset_source_pkg::CTRL_OFFSET) begin
        if (st_ff.wstrb[0]) begin
          nxt_st.wdt_en     = st_ff.wdata[reset_source_pkg::CTRL_WDT_EN_BIT];
          nxt_st.wdt_manual = st_ff.wdata[reset_source_pkg::CTRL_WDT_MANUAL_BIT];
        end
        if (st_ff.wstrb[1]) begin
          nxt_st.freq = st_ff.wdata[reset_source_pkg::CTRL_FREQ_LSB +: reset_source_pkg::FREQ_W];
        end
      end else if (st_ff.awaddr == reset_source_pkg::STATUS_OFFSET) begin
        // Write one to clear a cause bit
        if (st_ff.wstrb[0]) begin
          nxt_st.cause = st_ff.cause &
                         ~st_ff.wdata[reset_source_pkg::STAT_CAUSE_LSB +: reset_source_pkg::CAUSE_W];
        end
      end else begin
        nxt_st.bresp = reset_source_pkg::RESP_SLVERR;
      end
    end

    // Register read
    if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = 32'h0000_0000;
      nxt_st.rresp  = reset_source_pkg::RESP_OKAY;
      if (araddr == reset_source_pkg::CTRL_OFFSET) begin
        nxt_st.rdata[reset_source_pkg::CTRL_WDT_EN_BIT]     = st_ff.wdt_en;
        nxt_st.rdata[reset_source_pkg::CTRL_WDT_MANUAL_BIT] = st_ff.wdt_manual;
        nxt_st.rdata[reset_source_pkg::CTRL_FREQ_LSB +: reset_source_pkg::FREQ_W] = st_ff.freq;
      end else if (araddr == reset_source_pkg::STATUS_OFFSET) begin
        nxt_st.rdata[reset_source_pkg::STAT_CAUSE_LSB +: reset_source_pkg::CAUSE_W] = st_ff.cause;
        nxt_st.rdata[reset_source_pkg::STAT_POR_BIT]   = in_por;
        nxt_st.rdata[reset_source_pkg::STAT_MAN_BIT]   = in_man;
        nxt_st.rdata[reset_source_pkg::STAT_DEFER_BIT] = in_man && bus_busy;
      end else begin
        nxt_st.rresp = reset_source_pkg::RESP_SLVERR;
      end
    end

    // Reset sequencer
    case (st_ff.state)
      reset_source_pkg::RUN_ST: begin
        if (wdt_overflow && st_ff.wdt_en) begin
          if (st_ff.wdt_manual) begin
            nxt_st.state = reset_source_pkg::MAN_HOLD_ST;
            nxt_st.cause[reset_source_pkg::CAUSE_WDT_MAN_BIT] = 1'b1;
          end else begin
            nxt_st.state = reset_source_pkg::POR_HOLD_ST;
            nxt_st.src   = reset_source_pkg::SRC_WDT;
            nxt_st.cnt   = '0;
            nxt_st.cause[reset_source_pkg::CAUSE_WDT_POR_BIT] = 1'b1;
          end
        end
      end
      reset_source_pkg::POR_HOLD_ST: begin
        if (st_ff.src == reset_source_pkg::SRC_PIN) begin
          hold_low = !st_ff.pin_sync;
        end else if (st_ff.src == reset_source_pkg::SRC_DEBUG) begin
          hold_low = !st_ff.negate_seen;
        end
        if (st_ff.cnt < MIN_CNT) begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
        // A pin pulse shorter than the minimum does not release reset
        if (st_ff.src == reset_source_pkg::SRC_PIN && !hold_low && st_ff.cnt < MIN_CNT) begin
          nxt_st.cnt = '0;
        end
        if (!hold_low && st_ff.cnt >= MIN_CNT) begin
          nxt_st.state = reset_source_pkg::POR_EXC_ST;
        end
      end
      reset_source_pkg::POR_EXC_ST: begin
        nxt_st.state = reset_source_pkg::RUN_ST;
      end
      reset_source_pkg::MAN_HOLD_ST: begin
        if (!bus_busy) begin
          nxt_st.state = reset_source_pkg::MAN_EXC_ST;
        end
      end
      default: begin
        nxt_st.state = reset_source_pkg::RUN_ST;
      end
    endcase

    if (dbg_reset_negate && st_ff.src == reset_source_pkg::SRC_DEBUG) begin
      nxt_st.negate_seen = 1'b1;
    end

    // Debug assert outranks the watchdog; the pin outranks both
    if (dbg_reset_assert && st_ff.pin_sync) begin
      nxt_st.state       = reset_source_pkg::POR_HOLD_ST;
      nxt_st.src         = reset_source_pkg::SRC_DEBUG;
      nxt_st.cnt         = '0;
      nxt_st.negate_seen = 1'b0;
      nxt_st.cause[reset_source_pkg::CAUSE_DEBUG_BIT] = 1'b1;
    end
    if (!st_ff.pin_sync) begin
      if (!(in_por && st_ff.src == reset_source_pkg::SRC_PIN)) begin
        nxt_st.cnt = '0;
        nxt_st.cause[reset_source_pkg::CAUSE_PIN_BIT] = 1'b1;
      end
      nxt_st.state = reset_source_pkg::POR_HOLD_ST;
      nxt_st.src   = reset_source_pkg::SRC_PIN;
    end

    // Pin and debug resets clear the settings a watchdog reset keeps
    if (nxt_st.state == reset_source_pkg::POR_HOLD_ST && nxt_st.src != reset_source_pkg::SRC_WDT) begin
      nxt_st.wdt_en     = 1'b0;
      nxt_st.wdt_manual = 1'b0;
      nxt_st.freq       = reset_source_pkg::FREQ_RESET;
    end
  end

  // All-zero word: power-on hold from the pin, settings cleared
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  pin_sync_a: assert property (@(posedge clk) disable iff (!resetn)
    !power_on_reset_n [*3] |=> !periph_reset_n)
    else $error("Reset pin low three cycles without peripheral reset");

  pin_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    (in_por && !st_ff.pin_sync) |=> (in_por && st_ff.src == reset_source_pkg::SRC_PIN))
    else $error("Power-on reset left while pin still low");

  min_low_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(por_exception_start) |-> $past(st_ff.cnt) >= MIN_CNT && $past(in_por))
    else $error("Power-on exception before minimum low time");

  exc_once_a: assert property (@(posedge clk) disable iff (!resetn)
    por_exception_start |=> !por_exception_start && (!periph_reset_n || !$past(st_ff.pin_sync) || cpu_reset_n))
    else $error("Power-on exception start not a single pulse");

  debug_entry_a: assert property (@(posedge clk) disable iff (!resetn)
    (dbg_reset_assert && st_ff.pin_sync) |=>
      (!periph_reset_n && !retained_reset_n && st_ff.src == reset_source_pkg::SRC_DEBUG))
    else $error("Debug assert did not enter power-on reset");

  wdt_por_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_ff.state == reset_source_pkg::RUN_ST && wdt_overflow && st_ff.wdt_en && !st_ff.wdt_manual
     && !dbg_reset_assert && st_ff.pin_sync) |=>
      (!periph_reset_n && retained_reset_n && $stable(clock_frequency_control) && st_ff.wdt_en))
    else $error("Watchdog power-on reset lost its settings");

  wdt_man_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_ff.state == reset_source_pkg::RUN_ST && wdt_overflow && st_ff.wdt_en && st_ff.wdt_manual
     && !dbg_reset_assert && st_ff.pin_sync) |=> in_man ##1 (in_man || manual_exception_start || in_por))
    else $error("Watchdog manual reset not entered");

  man_defer_a: assert property (@(posedge clk) disable iff (!resetn)
    manual_exception_start |-> $past(in_man) && !$past(bus_busy))
    else $error("Manual exception started while bus released");

  man_scope_a: assert property (@(posedge clk) disable iff (!resetn)
    in_man |-> (periph_reset_n && retained_reset_n && !cpu_reset_n && bank_number_clear))
    else $error("Manual reset touched more than processor and bank bit");

  pin_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    (!st_ff.pin_sync && !in_por) |=>
      (!periph_reset_n && !retained_reset_n && clock_frequency_control == reset_source_pkg::FREQ_RESET))
    else $error("Pin reset did not clear the settings");

  pin_low_a: assert property (@(posedge clk) disable iff (!resetn)
    (in_por && st_ff.src == reset_source_pkg::SRC_PIN && !st_ff.pin_sync) |=> !por_exception_start)
    else $error("Power-on exception while the pin is low");

  debug_wait_a: assert property (@(posedge clk) disable iff (!resetn)
    (in_por && st_ff.src == reset_source_pkg::SRC_DEBUG && !st_ff.negate_seen) |=> !por_exception_start)
    else $error("Debug reset released before negate");

  man_once_a: assert property (@(posedge clk) disable iff (!resetn)
    manual_exception_start |=> (!manual_exception_start && !in_man))
    else $error("Manual exception start not a single pulse");

  wdt_flag_a: assert property (@(posedge clk) disable iff (!resetn)
    (st_ff.state == reset_source_pkg::RUN_ST && wdt_overflow && st_ff.wdt_en
     && !dbg_reset_assert && st_ff.pin_sync) |=> !watchdog_overflow_out_n)
    else $error("Watchdog reset not flagged on the overflow output");

endmodule

// File: dv/reset_supervisor.sv
// Purpose: Board reset supervisor that drives the reset pin of the reset source controller.
// Assumes: Clock runs during the power-up hold; lengths are counted in clk cycles.
// Notes:   The power-up hold is scaled down from the real oscillator settling time.
module reset_supervisor #(
  parameter int unsigned SETTLE = 50
) (
  input  wire logic        clk,               // Board clock
  input  wire logic        pulse_req,         // Start a low pulse on the pin
  input  wire logic [15:0] pulse_len,         // Pulse length in cycles
  input  wire logic        wdt_out_n,         // Watchdog overflow output of the controller
  output logic             power_on_reset_n,  // Reset pin, active low
  output logic             board_reset_n      // System reset of the other board parts
);
  timeunit 1ns;
  timeprecision 1ps;
  // Reset pin low from power-up until the oscillator has settled
  logic [15:0] low_ff = 16'(SETTLE);
  always @(posedge clk) begin
    if (pulse_req) begin
      low_ff <= pulse_len;
    end else if (low_ff != 16'h0) begin
      low_ff <= low_ff - 16'h1;
    end
  end
  assign power_on_reset_n = (low_ff == 16'h0);
  // Either source resets the board; the overflow output never drives the pin itself
  assign board_reset_n = power_on_reset_n && wdt_out_n;
endmodule

// File: dv/reset_source_control_test.sv
// Purpose: Self-checking bench of the reset source controller.
// Assumes: Register access over AXI4-Lite; supervisor model drives the reset pin.
// Notes:   Outputs are sampled 1 ns after the rising edge; the AXI4-Lite tasks sample at the falling edge.
module reset_source_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MIN = 20;
  logic        clk = 1'b0, resetn = 1'b0, pulse_req = 1'b0;
  logic        dbg_reset_assert = 1'b0, dbg_reset_negate = 1'b0, wdt_overflow = 1'b0;
  logic        bus_released = 1'b0, dma_burst_active = 1'b0;
  logic [15:0] pulse_len = 16'h0;
  wire logic   power_on_reset_n, board_reset_n;
  logic        periph_reset_n, cpu_reset_n, retained_reset_n, bank_number_clear;
  logic        por_exception_start, manual_exception_start, watchdog_overflow_out_n;
  logic [reset_source_pkg::FREQ_W-1:0] clock_frequency_control;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, seen;
  logic [1:0]  bresp, rresp, r;
  int          failures = 0, n_compared = 0, cycles = 0, cyc;

  reset_supervisor u_reset_supervisor (.clk, .pulse_req, .pulse_len, .wdt_out_n(watchdog_overflow_out_n),
    .power_on_reset_n, .board_reset_n);
  reset_source_control #(.MIN_LOW(MIN)) u_reset_source_control (.clk, .resetn, .power_on_reset_n,
    .dbg_reset_assert, .dbg_reset_negate, .wdt_overflow, .bus_released, .dma_burst_active,
    .periph_reset_n, .cpu_reset_n, .retained_reset_n, .bank_number_clear, .por_exception_start,
    .manual_exception_start, .watchdog_overflow_out_n, .clock_frequency_control, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_write(input logic [31:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge clk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      resp = bresp;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ar_ok, r_ok;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge clk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      v = rdata;
      resp = rresp;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  // Counts edges until the chosen exception pulse is seen or the limit runs out
  task automatic wait_exc(input bit man, input int lim, output logic hit, output int n);
    hit = 1'b0;
    n = 0;
    while (!hit && n < lim) begin
      @(posedge clk);
      #1;
      n++;
      hit = man ? (manual_exception_start === 1'b1) : (por_exception_start === 1'b1);
    end
  endtask

  // One-cycle pulse: 0 watchdog overflow, 1 debug assert, 2 debug negate
  task automatic fire(input int k);
    @(posedge clk);
    case (k)
      0: wdt_overflow <= 1'b1;
      1: dbg_reset_assert <= 1'b1;
      default: dbg_reset_negate <= 1'b1;
    endcase
    @(posedge clk);
    wdt_overflow <= 1'b0;
    dbg_reset_assert <= 1'b0;
    dbg_reset_negate <= 1'b0;
    #1;
  endtask

  task automatic pin_pulse(input int n);
    @(posedge clk);
    pulse_len <= 16'(n);
    pulse_req <= 1'b1;
    @(posedge clk);
    pulse_req <= 1'b0;
    #1;
    wait (power_on_reset_n === 1'b1);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    check("periph_reset_n in pin hold", periph_reset_n, 32'h0);
    check("cpu_reset_n in pin hold", cpu_reset_n, 32'h0);
    wait (power_on_reset_n === 1'b1);
    wait_exc(1'b0, 60, seen, cyc);
    check("exception after pin rise", 32'(seen && cyc >= 2 && cyc <= 4), 32'h1);
    check("resets released", {periph_reset_n, cpu_reset_n, retained_reset_n}, 32'h7);
    $display("test pin power-on done");
    pin_pulse(MIN / 2);
    wait_exc(1'b0, 30, seen, cyc);
    check("exception after short pin low", seen, 32'h0);
    check("periph_reset_n after short low", periph_reset_n, 32'h0);
    pin_pulse(MIN);
    wait_exc(1'b0, 30, seen, cyc);
    check("exception after full pin low", seen, 32'h1);
    $display("test short pin low done");
    axi_write(reset_source_pkg::CTRL_OFFSET, 32'h0000_5A01, r);
    check("ctrl write resp", r, reset_source_pkg::RESP_OKAY);
    check("clock_frequency_control", clock_frequency_control, 32'h5A);
    fire(0);
    check("periph_reset_n wdt por", periph_reset_n, 32'h0);
    check("retained_reset_n wdt por", retained_reset_n, 32'h1);
    check("watchdog_overflow_out_n wdt por", watchdog_overflow_out_n, 32'h0);
    check("board_reset_n wdt por", board_reset_n, 32'h0);
    wait_exc(1'b0, 40, seen, cyc);
    check("wdt por exception", 32'(seen && cyc >= MIN), 32'h1);
    axi_read(reset_source_pkg::CTRL_OFFSET, d, r);
    check("ctrl kept", d, 32'h0000_5A01);
    check("board_reset_n after wdt por", board_reset_n, 32'h1);
    $display("test watchdog power-on done");
    axi_write(reset_source_pkg::CTRL_OFFSET, 32'h0000_5A03, r);
    @(posedge clk);
    bus_released <= 1'b1;
    fire(0);
    check("cpu_reset_n manual", cpu_reset_n, 32'h0);
    check("bank_number_clear manual", bank_number_clear, 32'h1);
    check("watchdog_overflow_out_n manual", watchdog_overflow_out_n, 32'h0);
    check("other resets manual", {periph_reset_n, retained_reset_n}, 32'h3);
    wait_exc(1'b1, 10, seen, cyc);
    check("manual exception while bus released", seen, 32'h0);
    axi_read(reset_source_pkg::STATUS_OFFSET, d, r);
    check("status hold and defer", d[10:8], 32'h6);
    @(posedge clk);
    bus_released <= 1'b0;
    dma_burst_active <= 1'b1;
    wait_exc(1'b1, 8, seen, cyc);
    check("manual exception during dma burst", seen, 32'h0);
    @(posedge clk);
    dma_burst_active <= 1'b0;
    wait_exc(1'b1, 4, seen, cyc);
    check("manual exception after bus back", seen, 32'h1);
    check("frequency kept by manual", clock_frequency_control, 32'h5A);
    axi_read(reset_source_pkg::STATUS_OFFSET, d, r);
    check("status causes", d[3:0], 32'hD);
    $display("test watchdog manual done");
    fire(1);
    check("resets on debug assert", {periph_reset_n, retained_reset_n}, 32'h0);
    repeat (MIN) @(posedge clk);
    #1;
    check("periph_reset_n until negate", periph_reset_n, 32'h0);
    fire(2);
    wait_exc(1'b0, 4, seen, cyc);
    check("debug exception after negate", 32'(seen && cyc == 1), 32'h1);
    axi_read(reset_source_pkg::CTRL_OFFSET, d, r);
    check("ctrl cleared by debug reset", d, 32'h0);
    fire(0);
    check("overflow with watchdog disabled", cpu_reset_n, 32'h1);
    axi_read(32'h0000_0010, d, r);
    check("unmapped read resp", r, reset_source_pkg::RESP_SLVERR);
    check("unmapped read data", d, 32'h0);
    axi_write(32'h0000_0010, 32'hFFFF_FFFF, r);
    check("unmapped write resp", r, reset_source_pkg::RESP_SLVERR);
    $display("test debug reset done");
    print_verdict();
  end
endmodule
